// >>> design/tlh_pkg.sv
// package: register map, field layout and types of the lower timer half
package tlh_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TLH_OFF_CONTROL = 8'h00;
  localparam logic [7:0] TLH_OFF_COUNTER = 8'h04;
  localparam logic [7:0] TLH_OFF_PERIOD  = 8'h08;
  localparam logic [7:0] TLH_OFF_OPMODE  = 8'h0c;

  // ----------------------------------------------------------------
  // control and opmode register field positions
  // ----------------------------------------------------------------
  localparam int TLH_B_LEVEL_UPPER = 16;
  localparam int TLH_B_RSVD_HI     = 15;
  localparam int TLH_B_RSVD_LO     = 10;
  localparam int TLH_B_GATE        = 9;
  localparam int TLH_B_CLKSRC      = 8;
  localparam int TLH_B_MODE_HI     = 7;
  localparam int TLH_B_MODE_LO     = 6;
  localparam int TLH_B_PWID_HI     = 5;
  localparam int TLH_B_PULSE_WIDTH_LOWER     = 4;
  localparam int TLH_B_CP          = 3;
  localparam int TLH_B_INVIN       = 2;
  localparam int TLH_B_INVOUT      = 1;
  localparam int TLH_B_LEVEL_LOWER = 0;
  localparam int TLH_B_OPMODE_HI   = 1;
  localparam int TLH_B_OPMODE_LO   = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TLH_RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]  TLH_PULSE_NONE = 2'h0;
  localparam logic        TLH_SYNC_RST  = 1'h0;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TLH_EN_OFF,
    TLH_EN_ONCE,
    TLH_EN_CONT,
    TLH_EN_RSVD
  } tlh_enmode_t;

  typedef enum logic [1:0] {
    TLH_OP_GP64,
    TLH_OP_DUAL_UNCHAINED,
    TLH_OP_WATCHDOG,
    TLH_OP_DUAL_CHAINED
  } tlh_opmode_t;

  typedef struct packed {
    logic        gate;
    logic        clksrc;
    tlh_enmode_t mode;
    logic [1:0]  pwid;
    logic        cp;
    logic        invin;
    logic        invout;
  } tlh_ctrl_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tlh_bus_t;

endpackage

// >>> design/tlh_sync.sv
// two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tlh_sync
  import tlh_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= {WIDTH{TLH_SYNC_RST}};
      sync_o <= {WIDTH{TLH_SYNC_RST}};
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule
`default_nettype wire

// >>> design/tlh_timer.sv
// lower timer half: control register, clock selection, counter, output generation
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tlh_timer
  import tlh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rd_data_o,
  input  wire logic        timer_in_i,
  input  wire logic        output_level_upper_i,
  output logic             timer_out_pin_lower_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tlh_bus_t    bus;
  tlh_ctrl_t   ctrl_r;
  tlh_opmode_t opmode_r;
  logic [31:0] count_r;
  logic [31:0] period_r;
  logic        level_r;
  logic [1:0]  pulse_left_r;
  logic        pin_prev_r;
  logic        rd_valid_r;
  logic        pin_sync;
  logic        pin_src;
  logic        tick;
  logic        running;
  logic        hit;
  logic        pulse_mode;
  logic        level_nxt;
  logic [31:0] count_inc;

  assign bus = '{addr: addr_i, wdata: wr_data_i, wr: wr_i, rd: rd_i};

  // ----------------------------------------------------------------
  // timer input
  // ----------------------------------------------------------------
  tlh_sync #(
    .WIDTH (1)
  ) u_in_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (timer_in_i),
    .sync_o  (pin_sync)
  );

  // inversion only matters when the pin is the clock
  assign pin_src = ctrl_r.clksrc ? (pin_sync ^ ctrl_r.invin) : pin_sync;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_prev_r <= TLH_SYNC_RST;
    else
      pin_prev_r <= pin_src;
  end

  // pin clock counts on its rising edge; internal clock ticks every cycle, or only while the pin is high when gated
  always_comb
  begin
    if (ctrl_r.clksrc)
      tick = pin_src && !pin_prev_r;
    else if (ctrl_r.gate)
      tick = pin_sync;
    else
      tick = 1'b1;
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  assign running   = (ctrl_r.mode == TLH_EN_ONCE) || (ctrl_r.mode == TLH_EN_CONT);
  assign count_inc = count_r + 32'h0000_0001;
  assign hit       = tick && running && (count_r != period_r) && (count_inc == period_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_r <= TLH_RST_WORD;
    else if (bus.wr && bus.addr == TLH_OFF_COUNTER)
      count_r <= bus.wdata;
    else if (tick)
    begin
      case (ctrl_r.mode)
        TLH_EN_ONCE:
          if (count_r != period_r)
            count_r <= count_inc;
        TLH_EN_CONT:
          if (count_r == period_r)
            count_r <= TLH_RST_WORD;
          else
            count_r <= count_inc;
        default:
          count_r <= count_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output generation
  // ----------------------------------------------------------------
  assign pulse_mode = (opmode_r == TLH_OP_WATCHDOG) || !ctrl_r.cp;

  always_comb
  begin
    level_nxt = level_r;
    if (hit)
      level_nxt = pulse_mode ? 1'b1 : !level_r;
    else if (pulse_mode && tick && level_r && pulse_left_r == TLH_PULSE_NONE)
      level_nxt = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pulse_left_r <= TLH_PULSE_NONE;
    else if (hit && pulse_mode)
      pulse_left_r <= ctrl_r.pwid;
    else if (tick && pulse_left_r != TLH_PULSE_NONE)
      pulse_left_r <= pulse_left_r - 2'h1;
  end

  // pin follows level through the invert bit; one flop keeps it glitch free
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_r               <= 1'b0;
      timer_out_pin_lower_o <= 1'b0;
    end
    else
    begin
      level_r               <= level_nxt;
      timer_out_pin_lower_o <= level_nxt ^ ctrl_r.invout;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // status and reserved bits have no storage, so writes cannot reach them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= tlh_ctrl_t'(TLH_RST_WORD[TLH_B_GATE:TLH_B_INVOUT]);
    else if (bus.wr && bus.addr == TLH_OFF_CONTROL)
      ctrl_r <= tlh_ctrl_t'(bus.wdata[TLH_B_GATE:TLH_B_INVOUT]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_r <= TLH_RST_WORD;
    else if (bus.wr && bus.addr == TLH_OFF_PERIOD)
      period_r <= bus.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      opmode_r <= TLH_OP_GP64;
    else if (bus.wr && bus.addr == TLH_OFF_OPMODE)
      opmode_r <= tlh_opmode_t'(bus.wdata[TLH_B_OPMODE_HI:TLH_B_OPMODE_LO]);
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o  <= TLH_RST_WORD;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= bus.rd;
      rd_data_o  <= TLH_RST_WORD;
      if (bus.rd)
      begin
        if (bus.addr == TLH_OFF_CONTROL)
        begin
          rd_data_o[TLH_B_LEVEL_UPPER]          <= output_level_upper_i;
          rd_data_o[TLH_B_GATE:TLH_B_INVOUT]    <= ctrl_r;
          rd_data_o[TLH_B_LEVEL_LOWER]          <= level_r;
        end
        else if (bus.addr == TLH_OFF_COUNTER)
          rd_data_o <= count_r;
        else if (bus.addr == TLH_OFF_PERIOD)
          rd_data_o <= period_r;
        else if (bus.addr == TLH_OFF_OPMODE)
          rd_data_o[TLH_B_OPMODE_HI:TLH_B_OPMODE_LO] <= opmode_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] rd_addr_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_addr_r <= 8'h00;
    else
      rd_addr_r <= bus.addr;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  upper_level_read_a: assert property (
    bus.rd && bus.addr == TLH_OFF_CONTROL
    |=> rd_data_o[TLH_B_LEVEL_UPPER] == $past(output_level_upper_i))
    else $error("upper level misreported");

  reserved_zero_a: assert property (
    rd_valid_r && rd_addr_r == TLH_OFF_CONTROL |-> rd_data_o[TLH_B_RSVD_HI:TLH_B_RSVD_LO] == 6'h00)
    else $error("reserved control bits not zero");

  lower_level_read_a: assert property (
    bus.rd && bus.addr == TLH_OFF_CONTROL
    |=> rd_data_o[TLH_B_LEVEL_LOWER] == $past(level_r))
    else $error("lower level misreported");

  // idle bus must read zero so stale words never leak
  idle_read_zero_a: assert property (
    !rd_valid_r |-> rd_data_o == TLH_RST_WORD)
    else $error("read data not zero outside a read");

  gate_low_a: assert property (
    !ctrl_r.clksrc && ctrl_r.gate && !pin_sync |-> !tick)
    else $error("gated timer ticked with input low");

  pin_edge_a: assert property (
    ctrl_r.clksrc && tick |-> pin_src && !pin_prev_r)
    else $error("pin clock ticked without rising edge");

  disabled_hold_a: assert property (
    ctrl_r.mode == TLH_EN_OFF && !bus.wr |=> $stable(count_r))
    else $error("disabled counter moved");

  oneshot_stop_a: assert property (
    ctrl_r.mode == TLH_EN_ONCE && count_r == period_r && !bus.wr |=> $stable(count_r))
    else $error("one-shot counter passed period");

  cont_wrap_a: assert property (
    ctrl_r.mode == TLH_EN_CONT && tick && count_r == period_r && !bus.wr
    |=> count_r == 32'h0000_0000)
    else $error("continuous counter did not wrap");

  pulse_start_a: assert property (
    hit && pulse_mode |=> level_r && pulse_left_r == $past(ctrl_r.pwid))
    else $error("pulse not started at period");

  pulse_end_a: assert property (
    pulse_mode && tick && !hit && level_r && pulse_left_r == 2'h0 |=> !level_r)
    else $error("pulse outlived its width");

  wd_pulse_a: assert property (
    hit && opmode_r == TLH_OP_WATCHDOG |=> level_r)
    else $error("watchdog mode did not force pulse");

  clock_toggle_a: assert property (
    hit && !pulse_mode |=> level_r != $past(level_r))
    else $error("clock mode did not toggle");

  pin_invert_a: assert property (
    timer_out_pin_lower_o == (level_r ^ $past(ctrl_r.invout)))
    else $error("output pin not level xor invert");

  cov_oneshot_c: cover property (ctrl_r.mode == TLH_EN_ONCE && hit);
  cov_wrap_c: cover property (ctrl_r.mode == TLH_EN_CONT && tick && count_r == period_r);
  cov_pulse4_c: cover property (hit && pulse_mode && ctrl_r.pwid == 2'h3);
  cov_toggle_c: cover property (hit && !pulse_mode);
  cov_gated_c: cover property (ctrl_r.gate && !ctrl_r.clksrc && tick && running);

endmodule
`default_nettype wire

// >>> test/tb.sv
// testbench: register, counting and output checks of the lower timer half
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tlh_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, up_r = 1'b0;
  logic run_r = 1'b0, lvl_r = 1'b0, tin, pin;
  logic [7:0]  addr_r = 8'h00;
  logic [31:0] wd_r = 32'h0, rdat, v, c1;
  int n_errors = 0, check_count = 0, hi, per, p, w;
  tlh_pin_model pm (.clk_i(clk_i), .run_i(run_r), .lvl_i(lvl_r), .half_i(4'h3), .pin_o(tin));
  tlh_timer dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_r), .wr_data_i(wd_r),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdat), .timer_in_i(tin),
    .output_level_upper_i(up_r), .timer_out_pin_lower_o(pin));
  initial forever #12.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] hi4, input logic [1:0] pw,
                                      input logic [2:0] lo3);
    return {22'h0, hi4, pw, lo3, 1'b0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_r <= a; wd_r <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_r <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // high time of the next output pulse, then rise-to-rise span
  task automatic meas(output int h, output int s);
    int k;
    k = 0;
    while (pin !== 1'b0 && k < 300) begin tick(1); k++; end
    while (pin !== 1'b1 && k < 600) begin tick(1); k++; end
    h = 0;
    while (pin === 1'b1 && h < 300) begin tick(1); h++; end
    s = h;
    while (pin !== 1'b1 && s < 600) begin tick(1); s++; end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    p = $urandom(32'h1c79);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(TLH_OFF_CONTROL, v);
    chk(v, 32'h0);
    chk({31'h0, pin}, 32'h0);
    up_r <= 1'b1;
    wr(TLH_OFF_CONTROL, 32'hffff_ffff);
    rd(TLH_OFF_CONTROL, v);
    chk(v, 32'h0001_03fe);
    chk({31'h0, pin}, 32'h1);
    rd(8'h10, v);
    chk(v, 32'h0);
    // pulse and clock outputs, random period, every width
    for (w = 0; w < 4; w++)
    begin
      p = 4 + $urandom_range(5);
      up_r <= $urandom_range(1);
      wr(TLH_OFF_CONTROL, 32'h0);
      wr(TLH_OFF_COUNTER, 32'h0);
      wr(TLH_OFF_PERIOD, p);
      wr(TLH_OFF_OPMODE, {30'h0, w == 3 ? TLH_OP_WATCHDOG : TLH_OP_GP64});
      wr(TLH_OFF_CONTROL, ctl(4'h2, w[1:0], {w == 3, 2'h0}));
      meas(hi, per);
      chk(hi, w + 1);
      chk(per, p + 1);
      rd(TLH_OFF_CONTROL, v);
      chk(v[16], up_r);
    end
    wr(TLH_OFF_OPMODE, 32'h0);
    wr(TLH_OFF_CONTROL, ctl(4'h2, 2'h0, 3'h4));
    meas(hi, per);
    chk(hi, p + 1);
    chk(per, 2 * (p + 1));
    // one-shot stops on the period, disabled holds
    wr(TLH_OFF_CONTROL, 32'h0);
    wr(TLH_OFF_COUNTER, 32'h0);
    wr(TLH_OFF_CONTROL, ctl(4'h1, 2'h0, 3'h0));
    tick(3 * p);
    rd(TLH_OFF_COUNTER, v);
    chk(v, p);
    wr(TLH_OFF_PERIOD, 32'hffff);
    wr(TLH_OFF_CONTROL, ctl(4'h2, 2'h0, 3'h0));
    tick(5);
    wr(TLH_OFF_CONTROL, 32'h0);
    rd(TLH_OFF_COUNTER, c1);
    tick(20);
    rd(TLH_OFF_COUNTER, v);
    chk(v, c1);
    // gating on the internal clock
    wr(TLH_OFF_CONTROL, ctl(4'ha, 2'h0, 3'h0));
    rd(TLH_OFF_COUNTER, c1);
    tick(20);
    rd(TLH_OFF_COUNTER, v);
    chk(v, c1);
    lvl_r <= 1'b1;
    tick(10);
    rd(TLH_OFF_COUNTER, c1);
    tick(20);
    rd(TLH_OFF_COUNTER, v);
    chk(v - c1 >= 21 && v - c1 <= 23, 1);
    // pin source, plain and inverted: one count per rising edge
    for (w = 0; w < 2; w++)
    begin
      wr(TLH_OFF_CONTROL, ctl(4'h6, 2'h0, {1'b0, w[0], 1'b0}));
      run_r <= 1'b1;
      tick(8);
      rd(TLH_OFF_COUNTER, c1);
      tick(80);
      rd(TLH_OFF_COUNTER, v);
      run_r <= 1'b0;
      chk(v - c1 >= 10 && v - c1 <= 12, 1);
    end
    stop_test();
  end
  // hang guard, well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// >>> test/tlh_pin_model.sv
// partner: drives the timer input pin, toggling or holding a level
`timescale 1ns/1ps
`default_nettype none
module tlh_pin_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       lvl_i,
  input  wire logic [3:0] half_i,
  output logic            pin_o
);
  logic [3:0] cnt_r = 4'h0;
  logic       tog_r = 1'b0;
  // stopped pin shows the held level, never a stale toggle
  assign pin_o = run_i ? tog_r : lvl_i;
  always_ff @(posedge clk_i)
  begin
    if (!run_i || cnt_r == half_i)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
    if (run_i && cnt_r == half_i)
      tog_r <= ~tog_r;
  end
endmodule
`default_nettype wire
